// file: hw/mip_crc8.sv
// one-byte step of the packet error code, msb first
module mip_crc8
    import mip_pkg::*;
(
    input wire logic [7:0] crc_in,
    input wire logic [7:0] data,
    output logic [7:0] crc_out
);
    always_comb begin
        logic [7:0] c;
        c = crc_in ^ data;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
        end
        crc_out = c;
    end
endmodule

// file: hw/mip_ctrl.sv
// multi-master two-wire controller with packet error code, wishbone slave
//
// Local design decision: the Wishbone slave port.
module mip_ctrl
    import mip_pkg::*;
(
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [31:0] ADR_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    input wire logic WE_I,
    input wire logic [3:0] SEL_I,
    input wire logic STB_I,
    input wire logic CYC_I,
    output logic ACK_O,
    output logic IRQ,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire logic SCL_IN,
    output logic SCL_OUT,
    output logic SCL_OE
);
    import mip_pkg::*;

    mip_state_t r;
    mip_state_t next_r;
    mip_lines_t ln;
    logic [7:0] crc_byte;
    logic [7:0] crc_new;

    mip_sync #(.W(2)) u_sync (
        .clk(CLK),
        .arst_n(ARST_N),
        .d({SDA_IN, SCL_IN}),
        .q(ln)
    );

    // one checker serves both ends; only one completes a byte at a time
    assign crc_byte = (r.st != M_IDLE) ? {r.sh[6:0], ln.sda} : r.s_sh;

    mip_crc8 u_crc (
        .crc_in(r.crc_acc),
        .data(crc_byte),
        .crc_out(crc_new)
    );

    always_comb begin
        mip_state_t n;
        logic [7:0] rd;
        logic [7:0] wd;
        logic wr;
        logic mapped;
        logic [6:0] idx;
        logic [15:0] half;
        logic tx;
        logic idle;
        logic hi_end;
        logic s_rise;
        logic s_fall;
        logic hit;
        n = r;
        rd = 8'h00;
        wd = DAT_I[7:0];
        idx = ADR_I[8:2];
        mapped = (ADR_I[31:9] == 23'h000000) && (idx >= IDX_OWN) && (idx <= IDX_BAUD);
        half = 16'(HALF_BASE << r.bd);
        tx = r.addr_ph | ~r.mdir;
        idle = (r.st == M_IDLE);
        s_rise = ln.scl & ~r.prev.scl;
        s_fall = ~ln.scl & r.prev.scl;
        hit = 1'b0;
        hi_end = 1'b0;

        // register bus: answer one cycle after the request, unmapped reads zero
        n.ack = CYC_I & STB_I & ~r.ack;
        wr = n.ack & WE_I & SEL_I[0] & mapped;
        case (idx)
            IDX_OWN: rd = r.own;
            IDX_CR1: rd = {r.on, r.ie, 1'b0, 1'b0, r.ackdis, r.rsreq, r.pecb, 1'b0};
            IDX_CR2: rd = {r.al, r.nak, r.busy, r.mst, r.mdir, 2'b00, r.crcerr};
            IDX_SR: rd = {r.rxif, r.txif, r.match, r.srw, r.rxak, r.crcbf, r.txbe, r.rxbf};
            IDX_TX: rd = r.tdr;
            IDX_RX: rd = r.rdr;
            IDX_CRC: rd = r.crc;
            IDX_BAUD: rd = {5'h00, r.bd};
            default: rd = 8'h00;
        endcase
        if (n.ack) begin
            n.rdata = mapped ? rd : 8'h00;
        end
        if (n.ack && !WE_I && mapped) begin
            if (idx == IDX_RX) begin
                n.rxbf = 1'b0;
            end
            if (idx == IDX_CRC) begin
                n.crcbf = 1'b0;
            end
        end
        if (wr) begin
            case (idx)
                IDX_OWN: n.own = wd;
                IDX_CR1: begin
                    n.on = wd[B_ON];
                    n.ie = wd[B_IE];
                    n.ackdis = wd[B_ACKDIS];
                    n.rsreq = wd[B_RS];
                    n.pecb = wd[B_PEC];
                    if (wd[B_CLRBB]) begin
                        n.busy = 1'b0;
                    end
                end
                IDX_CR2: begin
                    if (!wd[B_AL]) begin
                        n.al = 1'b0;
                    end
                    if (!wd[B_NAK]) begin
                        n.nak = 1'b0;
                    end
                    n.mdir = wd[B_DIR];
                    if (wd[B_MST] && !r.mst && r.busy) begin
                        n.al = 1'b1;
                    end else begin
                        n.mst = wd[B_MST] & r.on;
                    end
                end
                IDX_SR: begin
                    if (!wd[B_RXIF]) begin
                        n.rxif = 1'b0;
                    end
                    if (!wd[B_TXIF]) begin
                        n.txif = 1'b0;
                    end
                end
                IDX_TX: begin
                    n.tdr = wd;
                    n.txbe = 1'b0;
                end
                IDX_BAUD: n.bd = wd[2:0];
                default: hit = 1'b0;
            endcase
        end

        if (r.cnt != 16'h0000) begin
            n.cnt = r.cnt - 16'h0001;
        end

        // master engine; hardware events below override software clears
        unique case (r.st)
            M_IDLE: begin
                if (r.mst && r.on && !r.busy && ln.scl && ln.sda) begin
                    n.sda_drv = 1'b1;
                    n.st = M_START;
                    n.cnt = half;
                end
            end
            M_START: begin
                if (r.cnt == 16'h0000) begin
                    n.rsreq = 1'b0;
                    n.sh = {r.own[7:1], r.mdir};
                    n.addr_ph = 1'b1;
                    n.ld = 1'b0;
                    n.bitn = 4'h0;
                    n.crc_acc = CRC_INIT;
                    n.scl_drv = 1'b1;
                    n.st = M_LOW;
                    n.cnt = half;
                end
            end
            M_LOW: begin
                n.scl_drv = 1'b1;
                if (r.ld) begin
                    // wait holding scl low until software refills
                    n.cnt = half;
                    if (!n.txbe) begin
                        n.sh = n.tdr;
                        n.txbe = 1'b1;
                        n.txif = 1'b1;
                        n.ld = 1'b0;
                    end
                end else begin
                    // msb first, ack on ninth clock; ack per disable
                    if (r.bitn < ACK_BIT) begin
                        n.sda_drv = tx & ~r.sh[7];
                    end else begin
                        n.sda_drv = ~tx & ~r.ackdis;
                    end
                    if (r.cnt == 16'h0000) begin
                        n.scl_drv = 1'b0;
                        n.st = M_HWAIT;
                    end
                end
            end
            M_HWAIT: begin
                // wait for the line itself to rise
                if (ln.scl) begin
                    n.st = M_HIGH;
                    n.cnt = half;
                end
            end
            M_HIGH: begin
                hi_end = (r.cnt == 16'h0000) | ~ln.scl;
                if (tx && r.bitn < ACK_BIT && !r.sda_drv && !ln.sda) begin
                    // silent drop to slave, flag raised
                    n.al = 1'b1;
                    n.mst = 1'b0;
                    n.rsreq = 1'b0;
                    n.sda_drv = 1'b0;
                    n.scl_drv = 1'b0;
                    n.st = M_IDLE;
                end else if (hi_end) begin
                    // first finished or line pulled low starts next low
                    n.scl_drv = 1'b1;
                    n.st = M_LOW;
                    n.cnt = half;
                    n.bitn = r.bitn + 4'h1;
                    if (r.bitn < ACK_BIT) begin
                        n.sh = {r.sh[6:0], ln.sda};
                    end
                    if (r.bitn == LAST_DATA_BIT) begin
                        // code over every byte on the wire
                        n.crc = crc_new;
                        n.crc_acc = crc_new;
                        n.crcbf = 1'b1;
                        if (!tx) begin
                            n.rdr = {r.sh[6:0], ln.sda};
                            n.rxbf = 1'b1;
                            n.rxif = 1'b1;
                            if (r.pecb) begin
                                n.crcerr = (crc_new != 8'h00);
                            end
                        end
                    end
                    if (r.bitn == ACK_BIT) begin
                        n.bitn = 4'h0;
                        n.addr_ph = 1'b0;
                        n.sda_drv = 1'b0;
                        if (tx) begin
                            n.rxak = ln.sda;
                            if (ln.sda) begin
                                n.nak = 1'b1;
                                n.mst = 1'b0;
                            end
                        end
                        n.ld = ~n.mst ? 1'b0 : (r.addr_ph ? ~r.mdir : ~r.mdir);
                        if (!n.mst) begin
                            n.rsreq = 1'b0;
                            n.sda_drv = 1'b1;
                            n.st = M_STOP1;
                        end else if (n.rsreq) begin
                            n.ld = 1'b0;
                            n.st = M_RSTART;
                        end
                    end
                end
            end
            M_STOP1: begin
                n.scl_drv = 1'b1;
                n.sda_drv = 1'b1;
                if (r.cnt == 16'h0000) begin
                    n.scl_drv = 1'b0;
                    n.st = M_STOP2;
                    n.cnt = half;
                end
            end
            M_STOP2: begin
                if (!ln.scl) begin
                    n.cnt = half;
                end else if (r.cnt == 16'h0000) begin
                    n.sda_drv = 1'b0;
                    n.st = M_IDLE;
                end
            end
            M_RSTART: begin
                n.sda_drv = 1'b0;
                if (r.scl_drv) begin
                    if (r.cnt == 16'h0000) begin
                        n.scl_drv = 1'b0;
                        n.cnt = half;
                    end
                end else if (!ln.scl) begin
                    n.cnt = half;
                end else if (r.cnt == 16'h0000) begin
                    n.sda_drv = 1'b1;
                    n.st = M_START;
                    n.cnt = half;
                end
            end
        endcase

        // line watcher and slave end
        if (ln.scl && r.prev.scl && r.prev.sda && !ln.sda) begin
            n.busy = 1'b1;
            n.pecb = 1'b0;
            n.crc_acc = CRC_INIT;
            n.s_act = 1'b1;
            n.s_addr = 1'b1;
            n.s_tx = 1'b0;
            n.s_bit = '1; // wraps to zero on the start's own scl fall
            n.s_sda = 1'b0;
            n.s_hold = 1'b0;
        end else if (ln.scl && r.prev.scl && !r.prev.sda && ln.sda) begin
            n.busy = 1'b0;
            n.s_act = 1'b0;
            n.s_sda = 1'b0;
            n.s_hold = 1'b0;
        end else if (r.s_act) begin
            if (s_rise && r.s_bit < ACK_BIT) begin
                n.s_sh = {r.s_sh[6:0], ln.sda};
            end
            if (s_rise && r.s_bit == ACK_BIT && r.s_tx && idle) begin
                n.rxak = ln.sda;
            end
            if (s_fall && r.s_bit == LAST_DATA_BIT) begin
                n.s_bit = ACK_BIT;
                if (idle) begin
                    n.crc = crc_new;
                    n.crc_acc = crc_new;
                    n.crcbf = 1'b1;
                    n.s_sda = 1'b0;
                end
                if (r.s_addr && idle) begin
                    if (r.s_sh[7:1] == r.own[7:1] || (r.own[0] &&
                        (r.s_sh[7:1] == ADDR_GENERAL || r.s_sh[7:1] == ADDR_EXTRA))) begin
                        n.s_sda = 1'b1;
                        n.match = 1'b1;
                        n.srw = r.s_sh[0];
                        n.s_tx = r.s_sh[0];
                        n.rdr = r.s_sh;
                    end else begin
                        n.s_act = 1'b0;
                    end
                end else if (!r.s_tx && idle) begin
                    n.rdr = r.s_sh;
                    n.rxbf = 1'b1;
                    n.rxif = 1'b1;
                    n.match = 1'b0;
                    if (r.pecb) begin
                        n.crcerr = (crc_new != 8'h00);
                    end
                    // withhold on mismatch or when disabled
                    n.s_sda = ~r.ackdis & ~(r.pecb & (crc_new != 8'h00));
                end
            end else if (s_fall && r.s_bit == ACK_BIT) begin
                n.s_bit = 4'h0;
                n.s_addr = 1'b0;
                n.s_sda = 1'b0;
                if (r.s_tx && idle) begin
                    if (r.s_addr || !r.rxak) begin
                        n.s_hold = 1'b1;
                    end else begin
                        n.s_act = 1'b0;
                    end
                end
            end else if (s_fall) begin
                n.s_bit = r.s_bit + 4'h1;
                if (r.s_tx) begin
                    n.s_sda = ~r.s_sh[7];
                end
            end
            // stretch scl until the transmit register is filled
            if (r.s_hold && !n.txbe) begin
                n.s_sh = n.tdr;
                n.txbe = 1'b1;
                n.txif = 1'b1;
                n.s_sda = ~n.tdr[7];
                n.s_hold = 1'b0;
            end
        end
        n.prev = ln;

        // disabled module returns flags to defaults, all but the code error flag
        if (!n.on) begin
            n.al = 1'b0;
            n.nak = 1'b0;
            n.busy = 1'b0;
            n.mst = 1'b0;
            n.rsreq = 1'b0;
            n.rxif = 1'b0;
            n.txif = 1'b0;
            n.match = 1'b0;
            n.srw = 1'b0;
            n.rxak = 1'b1;
            n.crcbf = 1'b0;
            n.txbe = 1'b1;
            n.rxbf = 1'b0;
            n.st = M_IDLE;
            n.sda_drv = 1'b0;
            n.scl_drv = 1'b0;
            n.s_act = 1'b0;
            n.s_sda = 1'b0;
            n.s_hold = 1'b0;
        end
        // slave drive only counts while not mastering the bus
        n.sda_oe = n.sda_drv | (n.s_sda & (n.st == M_IDLE));
        n.scl_oe = n.scl_drv | (n.s_hold & (n.st == M_IDLE));
        n.irq = n.ie & (n.txif | n.rxif | n.al | n.nak);
        next_r = n;
    end

    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            r <= '0;
            // address resets to a0, extended enable clear
            r.own <= OWN_RESET;
            r.bd <= BAUD_RESET;
            r.rxak <= 1'b1;
            r.txbe <= 1'b1;
            r.prev <= '1;
            r.st <= M_IDLE;
        end else begin
            next_r_apply: r <= next_r;
        end
    end

    assign DAT_O = {24'h000000, r.rdata};
    assign ACK_O = r.ack;
    assign IRQ = r.irq;
    assign SDA_OUT = 1'b0;
    assign SCL_OUT = 1'b0;
    assign SDA_OE = r.sda_oe;
    assign SCL_OE = r.scl_oe;
endmodule

// file: hw/mip_pkg.sv
// shared constants and types for the two-wire controller with packet error code
package mip_pkg;
    // register indices; the byte address is four times the index
    localparam logic [6:0] IDX_OWN = 7'h48;
    localparam logic [6:0] IDX_CR1 = 7'h49;
    localparam logic [6:0] IDX_CR2 = 7'h4a;
    localparam logic [6:0] IDX_SR = 7'h4b;
    localparam logic [6:0] IDX_TX = 7'h4c;
    localparam logic [6:0] IDX_RX = 7'h4d;
    localparam logic [6:0] IDX_CRC = 7'h4e;
    localparam logic [6:0] IDX_BAUD = 7'h4f;
    localparam logic [7:0] OWN_RESET = 8'ha0;
    localparam logic [2:0] BAUD_RESET = 3'h4;
    // control_one fields
    localparam int B_ON = 7;
    localparam int B_IE = 6;
    localparam int B_CLRBB = 5;
    localparam int B_ACKDIS = 3;
    localparam int B_RS = 2;
    localparam int B_PEC = 1;
    // control_two fields
    localparam int B_AL = 7;
    localparam int B_NAK = 6;
    localparam int B_BUSY = 5;
    localparam int B_MST = 4;
    localparam int B_DIR = 3;
    localparam int B_CRCE = 0;
    // status_flags fields
    localparam int B_RXIF = 7;
    localparam int B_TXIF = 6;
    localparam int B_MATCH = 5;
    localparam int B_SRW = 4;
    localparam int B_RXAK = 3;
    localparam int B_CRCBF = 2;
    localparam int B_TXBE = 1;
    localparam int B_RXBF = 0;
    // extended slave addresses
    localparam logic [6:0] ADDR_GENERAL = 7'h00;
    localparam logic [6:0] ADDR_EXTRA = 7'h0c;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;
    // system clock cycles per scl half period at divider zero
    localparam logic [15:0] HALF_BASE = 16'h000a;
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;
    localparam logic [3:0] ACK_BIT = 4'h8;

    typedef enum logic [2:0] {
        M_IDLE = 3'h0,
        M_START = 3'h1,
        M_LOW = 3'h2,
        M_HWAIT = 3'h3,
        M_HIGH = 3'h4,
        M_STOP1 = 3'h5,
        M_STOP2 = 3'h6,
        M_RSTART = 3'h7
    } mip_mstate_t;

    typedef struct packed {
        logic sda;
        logic scl;
    } mip_lines_t;

    typedef struct packed {
        logic ack;
        logic [7:0] rdata;
        logic irq;
        logic [7:0] own;
        logic on;
        logic ie;
        logic ackdis;
        logic rsreq;
        logic pecb;
        logic al;
        logic nak;
        logic busy;
        logic mst;
        logic mdir;
        logic crcerr;
        logic rxif;
        logic txif;
        logic match;
        logic srw;
        logic rxak;
        logic crcbf;
        logic txbe;
        logic rxbf;
        logic [7:0] tdr;
        logic [7:0] rdr;
        logic [7:0] crc;
        logic [7:0] crc_acc;
        logic [2:0] bd;
        mip_mstate_t st;
        logic [15:0] cnt;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic addr_ph;
        logic ld;
        logic sda_drv;
        logic scl_drv;
        logic [3:0] s_bit;
        logic [7:0] s_sh;
        logic s_act;
        logic s_addr;
        logic s_tx;
        logic s_sda;
        logic s_hold;
        mip_lines_t prev;
        logic sda_oe;
        logic scl_oe;
    } mip_state_t;
endpackage

// file: hw/mip_sync.sv
// two flip-flop synchroniser for asynchronous line levels
module mip_sync #(
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } mip_sync_state_t;

    mip_sync_state_t r;
    mip_sync_state_t next_r;

    always_comb begin
        next_r = r;
        next_r.s1 = d;
        next_r.s2 = r.s1;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '1; // idle lines are high, so no false edge after reset
        end else begin
            r <= next_r;
        end
    end

    assign q = r.s2;
endmodule

// file: verification/mip_ctrl_sva.sv
// assertions on the controller ports
module mip_ctrl_sva
    import mip_pkg::*;
(
    input wire logic CLK,
    input wire logic ARST_N,
    input wire logic [31:0] ADR_I,
    input wire logic [31:0] DAT_I,
    input wire logic [31:0] DAT_O,
    input wire logic WE_I,
    input wire logic STB_I,
    input wire logic CYC_I,
    input wire logic ACK_O,
    input wire logic IRQ,
    input wire logic SDA_IN,
    input wire logic SDA_OE,
    input wire logic SCL_IN,
    input wire logic SCL_OE
);
    logic cr1_wr;
    assign cr1_wr = CYC_I && STB_I && !ACK_O && WE_I && ADR_I[8:2] == IDX_CR1;
    default clocking @(posedge CLK); endclocking
    default disable iff (!ARST_N);
    a_ack_next: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O)
        else $error("ack late");
    a_ack_once: assert property (ACK_O |=> !ACK_O)
        else $error("ack held");
    a_upper_zero: assert property (ACK_O |-> DAT_O[31:8] == 24'h0)
        else $error("upper data set");
    a_clr_zero: assert property (ACK_O && !WE_I && ADR_I[8:2] == IDX_CR1
        |-> !DAT_O[B_CLRBB]) else $error("clear busy reads one");
    a_gate_quiet: assert property (cr1_wr && !DAT_I[B_IE] |-> ##2 !IRQ)
        else $error("irq while gated");
    a_off_clears: assert property (cr1_wr && !DAT_I[B_ON] |-> ##2 (!IRQ)[*2])
        else $error("irq while off");
    a_start_high: assert property ($rose(SDA_OE) && !SCL_OE && SCL_IN |-> $past(SDA_IN))
        else $error("start on low data");
    a_high_count: assert property ($rose(SCL_IN) |-> (!SCL_OE)[*4])
        else $error("high phase cut");
    c_write: cover property (cr1_wr);
    c_start: cover property ($rose(SDA_OE) && !SCL_OE);
    c_irq: cover property ($rose(IRQ));
endmodule
bind mip_ctrl mip_ctrl_sva mip_ctrl_sva_inst (.CLK(CLK), .ARST_N(ARST_N), .ADR_I(ADR_I),
    .DAT_I(DAT_I), .DAT_O(DAT_O), .WE_I(WE_I), .STB_I(STB_I), .CYC_I(CYC_I), .ACK_O(ACK_O),
    .IRQ(IRQ), .SDA_IN(SDA_IN), .SDA_OE(SDA_OE), .SCL_IN(SCL_IN), .SCL_OE(SCL_OE));

// file: verification/mip_ctrl_tb_top.sv
// bench: registers, slave addressing and a master call
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("ERROR %0t: got %h want %h", $time, g, e); end end
module mip_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import mip_pkg::*;
    logic CLK = 1'b0, ARST_N = 1'b0, WE_I = 1'b0, STB_I = 1'b0, CYC_I = 1'b0;
    logic [31:0] ADR_I = 32'h0, DAT_I = 32'h0, DAT_O;
    logic ACK_O, IRQ, SDA_OE, SCL_OE, f_sda, f_scl, sda, scl;
    logic [9:0] bits = 10'h0;
    logic [7:0] rd;
    logic [7:0] mid_cr = 8'h80, pdat = 8'h5a;
    int fails = 0, n_compared = 0;
    logic [7:0] ownv [6] = '{8'hd5, 8'hd5, 8'hd5, 8'hd5, 8'hd4, 8'hd4};
    logic [7:0] addv [6] = '{8'hd4, 8'h00, 8'h18, 8'h30, 8'h18, 8'h00};
    // pull-ups: a released line reads high
    assign sda = !(SDA_OE || f_sda);
    assign scl = !(SCL_OE || f_scl);
    always #20 CLK = ~CLK;
    always @(posedge scl) bits <= {bits[8:0], sda};
    mip_ctrl mip_ctrl_inst (.CLK(CLK), .ARST_N(ARST_N), .ADR_I(ADR_I), .DAT_I(DAT_I),
        .DAT_O(DAT_O), .WE_I(WE_I), .SEL_I(4'h1), .STB_I(STB_I), .CYC_I(CYC_I),
        .ACK_O(ACK_O), .IRQ(IRQ), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(SDA_OE),
        .SCL_IN(scl), .SCL_OUT(), .SCL_OE(SCL_OE));
    mip_far_master far (.sda(sda), .scl(scl), .sda_oe(f_sda), .scl_oe(f_scl));
    task automatic final_report();
        $display("compared %0d mismatched %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // reference code step: msb first, package polynomial
    function automatic logic [7:0] crc_step(input logic [7:0] c, d);
        logic [7:0] x;
        x = c ^ d;
        for (int i = 0; i < 8; i++) x = x[7] ? ((x << 1) ^ CRC_POLY) : (x << 1);
        return x;
    endfunction
    // a read compares under mask m with d; m zero skips it
    task automatic acc(input logic [6:0] idx, input logic we, input logic [7:0] d, m);
        int i;
        @(posedge CLK);
        {ADR_I, DAT_I, WE_I, CYC_I, STB_I} <= {23'h0, idx, 2'b00, 24'h0, d, we, 2'b11};
        for (i = 0; i < 20 && ACK_O !== 1'b1; i++) @(posedge CLK);
        rd = DAT_O[7:0];
        {CYC_I, STB_I} <= 2'b00;
        if (i == 20) begin
            fails++;
            final_report();
        end else if (m != 0) begin
            `CHK(rd & m, d)
        end
    endtask
    task automatic pollc(input logic [7:0] m, v);
        int i;
        rd = ~v;
        for (i = 0; i < 300 && (rd & m) !== v; i++) acc(IDX_CR2, 1'b0, 8'h00, 8'h00);
        `CHK(rd & m, v)
        if (i == 300) final_report();
    endtask
    task automatic frame(input logic [7:0] a, input logic ea, dat, ed);
        logic ack;
        far.start();
        far.put_byte(a, ack);
        `CHK(ack, ea)
        if (dat) begin
            acc(IDX_RX, 1'b0, 8'h00, 8'h00);
            if (mid_cr[B_PEC]) acc(IDX_CR1, 1'b1, mid_cr, 8'h00);
            far.put_byte(pdat, ack);
            `CHK(ack, ed)
        end
        far.stop();
    endtask
    initial begin
        repeat (6) @(posedge CLK);
        ARST_N <= 1'b1;
        acc(IDX_OWN, 1'b0, OWN_RESET, 8'hff);
        acc(IDX_CR1, 1'b0, 8'h00, 8'hff);
        acc(IDX_SR, 1'b0, 8'h0a, 8'hff);
        acc(7'h50, 1'b0, 8'h00, 8'hff);
        acc(IDX_CR1, 1'b1, 8'hea, 8'h00);
        acc(IDX_CR1, 1'b0, 8'hca, 8'hff);
        `CHK(IRQ, 1'b0)
        acc(IDX_CR1, 1'b1, 8'h80, 8'h00);
        far.start();
        repeat (8) @(posedge CLK);
        acc(IDX_CR2, 1'b0, 8'h20, 8'h20);
        acc(IDX_CR1, 1'b1, 8'ha0, 8'h00);
        acc(IDX_CR2, 1'b0, 8'h00, 8'h20);
        far.stop();
        $display("test registers done");
        for (int k = 0; k < 6; k++) begin
            acc(IDX_OWN, 1'b1, ownv[k], 8'h00);
            frame(addv[k], k < 3, 1'b0, 1'b0);
        end
        for (int j = 0; j < 2; j++) begin
            acc(IDX_CR1, 1'b1, j ? 8'h88 : 8'h80, 8'h00);
            frame(8'hd4, 1'b1, 1'b1, j == 0);
        end
        $display("test slave done");
        for (int p = 0; p < 2; p++) begin
            acc(IDX_CR1, 1'b1, 8'h80, 8'h00);
            mid_cr = 8'h82;
            pdat = p ? crc_step(CRC_INIT, 8'hd4) : 8'h5a;
            frame(8'hd4, 1'b1, 1'b1, p == 1);
            acc(IDX_CR2, 1'b0, {7'h00, p == 0}, 8'h01);
            acc(IDX_CRC, 1'b0, crc_step(crc_step(CRC_INIT, 8'hd4), pdat), 8'hff);
        end
        $display("test pec done");
        acc(IDX_CR1, 1'b1, 8'hc0, 8'h00);
        acc(IDX_BAUD, 1'b1, 8'h00, 8'h00);
        acc(IDX_OWN, 1'b1, 8'ha7, 8'h00);
        bits = 10'h0;
        acc(IDX_CR2, 1'b1, 8'h10, 8'h00);
        pollc(8'h40, 8'h40);
        pollc(8'h20, 8'h00);
        `CHK(bits, 10'b1010011010)
        `CHK(IRQ, 1'b1)
        acc(IDX_CR1, 1'b1, 8'h80, 8'h00);
        repeat (3) @(posedge CLK);
        `CHK(IRQ, 1'b0)
        acc(IDX_CR1, 1'b1, 8'h40, 8'h00);
        acc(IDX_CR2, 1'b0, 8'h00, 8'hc0);
        `CHK(IRQ, 1'b0)
        $display("test master done");
        final_report();
    end
endmodule

// file: verification/mip_far_master.sv
// far-side master clocking the shared lines at 320 ns a bit
module mip_far_master (
    input wire logic sda,
    input wire logic scl,
    output logic sda_oe = 1'b0,
    output logic scl_oe = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic start();
        #167 sda_oe = 1'b1;
        #160 scl_oe = 1'b1;
    endtask
    task automatic put_byte(input logic [7:0] b, output logic ack);
        logic stuck;
        stuck = 1'b0;
        for (int i = 8; i >= 0; i--) begin
            #80 sda_oe = (i > 0) ? !b[i-1] : 1'b0;
            #80 scl_oe = 1'b0;
            for (int w = 0; w < 400 && !scl; w++) #40;
            // a clock held past the bound reports an unknown acknowledge
            stuck = stuck | !scl;
            #80 ack = stuck ? 1'bx : !sda;
            #80 scl_oe = 1'b1;
        end
    endtask
    task automatic stop();
        #80 sda_oe = 1'b1;
        #80 scl_oe = 1'b0;
        #160 sda_oe = 1'b0;
    endtask
endmodule
